// >>> verilog/uoes_pkg.sv
// Constants, types and field layouts of the OUT endpoint status block.
package uoes_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [7:0] UOES_IDX_CTRL_LOW = 8'h14;
  localparam logic [7:0] UOES_IDX_CTRL_HIGH = 8'h15;
  localparam logic [7:0] UOES_IDX_INT_STATUS = 8'h16;
  localparam logic [7:0] UOES_IDX_INT_CLEAR = 8'h17;
  localparam logic [7:0] UOES_IDX_INT_ENABLE = 8'h18;
  localparam logic [7:0] UOES_IDX_FIFO_DATA = 8'h19;

  // ----------------------------------------------------------------------
  // Field positions of the low control register.
  // ----------------------------------------------------------------------
  localparam int UOES_LOW_READY = 0;
  localparam int UOES_LOW_FULL = 1;
  localparam int UOES_LOW_LOST = 2;
  localparam int UOES_LOW_DERR = 3;
  localparam int UOES_LOW_FLUSH = 4;
  localparam int UOES_LOW_STALL_REQ = 5;
  localparam int UOES_LOW_STALL_SENT = 6;
  localparam int UOES_LOW_CLR_TOGGLE = 7;

  // Field positions of the high control register.
  localparam int UOES_HIGH_ISO = 6;
  localparam int UOES_HIGH_DBL = 7;

  // Interrupt bit positions, shared by status, clear and enable.
  localparam int UOES_INT_READY = 0;
  localparam int UOES_INT_LOST = 1;
  localparam int UOES_INT_STALL = 2;
  localparam int UOES_INT_DERR = 3;

  // ----------------------------------------------------------------------
  // Reset values and FIFO geometry.
  // ----------------------------------------------------------------------
  localparam logic [7:0] UOES_RST_CTRL = 8'h00;
  localparam logic [3:0] UOES_RST_INT = 4'h0;
  localparam int UOES_PKT_BYTES = 64;
  localparam logic [6:0] UOES_PKT_MAX = 7'h40;
  localparam logic [1:0] UOES_CAP_DOUBLE = 2'h2;
  localparam logic [1:0] UOES_CAP_SINGLE = 2'h1;

  // Receive states, Gray coded along idle to take and idle to drop.
  typedef enum logic [1:0] {
    UOES_RX_IDLE = 2'b00,
    UOES_RX_TAKE = 2'b01,
    UOES_RX_DROP = 2'b10
  } uoes_rx_state_t;

  // Packet stream from the receive logic of the USB engine.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic eop;
    logic crc_err;
  } uoes_rx_t;

  // Handshake advice back to the USB engine.
  typedef struct packed {
    logic stall;
    logic nak;
    logic toggle;
  } uoes_hs_t;

endpackage : uoes_pkg

// >>> verilog/uoes_top.sv
// OUT endpoint control, status, packet FIFO and register slave.
`timescale 1ns/10ps
module uoes_top
  import uoes_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Packet stream from the USB engine.
  input wire uoes_rx_t rx_i,
  // Handshake advice and interrupt.
  output uoes_hs_t hs_o,
  output logic irq_o
);

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] widx;
  logic [7:0] wbyte;

  logic ready_ff;
  logic lost_ff;
  logic derr_ff;
  logic flush_ff;
  logic stall_req_ff;
  logic stall_sent_ff;
  logic iso_ff;
  logic dbl_ff;
  logic toggle_ff;
  logic [3:0] int_stat_ff;
  logic [3:0] int_en_ff;
  logic irq_ff;
  uoes_hs_t hs_ff;

  uoes_rx_state_t rx_state_ff;
  logic [6:0] wr_ptr_ff;
  logic [6:0] rd_ptr_ff;
  logic wr_slot_ff;
  logic rd_slot_ff;
  logic [1:0] pkt_cnt_ff;
  logic [6:0] len_ff [0:1];
  logic [7:0] mem_ff [0:1][0:UOES_PKT_BYTES-1];

  logic [1:0] cap;
  logic space;
  logic full;
  logic stall_act;
  logic admit;
  logic byte_take;
  logic commit;
  logic lost_ev;
  logic stall_ev;
  logic derr_ev;
  logic unload;
  logic pop;
  logic fifo_pop_byte;
  logic nxt_ready;
  logic [3:0] ev;
  logic [7:0] low_view;
  logic [7:0] high_view;
  logic [7:0] fifo_byte;

  // ----------------------------------------------------------------------
  // Bus slave: one wait state, then the access takes effect.
  // ----------------------------------------------------------------------

  // The access completes at the edge where waitrequest is seen low.
  assign acc = (avs_read_i | avs_write_i) & ~wait_ff;
  assign wr_acc = acc & avs_write_i & avs_byteenable_i[0];
  assign rd_acc = acc & avs_read_i;
  assign widx = {2'b00, avs_address_i[7:2]};
  assign wbyte = avs_writedata_i[7:0];

  // Waitrequest drops for exactly one cycle per request.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~((avs_read_i | avs_write_i) & wait_ff);
    end
  end

  // Read views of the two control registers; unused bits and the toggle clear bit read zero.
  assign low_view = {1'b0, stall_sent_ff, stall_req_ff, flush_ff,
                     derr_ff, lost_ff, full, ready_ff};
  assign high_view = {dbl_ff, iso_ff, 6'h00};
  assign fifo_byte = mem_ff[rd_slot_ff][rd_ptr_ff[5:0]];

  // Read data is captured in the wait cycle; unmapped indices read zero.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read_i & wait_ff) begin
      unique case (widx)
        UOES_IDX_CTRL_LOW: rdata_ff <= {24'h000000, low_view};
        UOES_IDX_CTRL_HIGH: rdata_ff <= {24'h000000, high_view};
        UOES_IDX_INT_STATUS: rdata_ff <= {28'h0000000, int_stat_ff};
        UOES_IDX_INT_ENABLE: rdata_ff <= {28'h0000000, int_en_ff};
        UOES_IDX_FIFO_DATA: rdata_ff <= {24'h000000, fifo_byte};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;

  // ----------------------------------------------------------------------
  // FIFO occupancy and receive admission.
  // ----------------------------------------------------------------------

  // Capacity is two packets with double buffering, else one.
  assign cap = dbl_ff ? UOES_CAP_DOUBLE : UOES_CAP_SINGLE;
  assign space = pkt_cnt_ff < cap;
  assign full = pkt_cnt_ff >= cap;
  // Stalling only applies to bulk and interrupt operation.
  assign stall_act = stall_req_ff & ~iso_ff;

  // A new packet is admitted only with room and no stall.
  assign admit = (rx_state_ff == UOES_RX_TAKE) |
                 ((rx_state_ff == UOES_RX_IDLE) & space & ~stall_act);
  assign byte_take = rx_i.valid & admit & (wr_ptr_ff < UOES_PKT_MAX);
  // A bad CRC is kept only in isochronous mode.
  assign commit = rx_i.eop & admit & (iso_ff | ~rx_i.crc_err);
  assign derr_ev = commit & iso_ff & rx_i.crc_err;
  // Without a stall, a packet that found no room is lost and flagged.
  assign lost_ev = rx_i.eop & ~stall_act & ~admit;
  assign stall_ev = rx_i.eop & stall_act;

  // Receive sequencer: take or drop the bytes of one packet.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_ff <= UOES_RX_IDLE;
    end else if (rx_i.eop) begin
      rx_state_ff <= UOES_RX_IDLE;
    end else if (rx_i.valid & (rx_state_ff == UOES_RX_IDLE)) begin
      rx_state_ff <= admit ? UOES_RX_TAKE : UOES_RX_DROP;
    end
  end

  // Write pointer walks the bytes of the packet being received.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff <= 7'h00;
    end else if (rx_i.eop) begin
      wr_ptr_ff <= 7'h00;
    end else if (byte_take) begin
      wr_ptr_ff <= wr_ptr_ff + 7'h01;
    end
  end

  // Packet storage in flip-flops; data needs no reset.
  always_ff @(posedge sys_clk_i) begin
    if (byte_take) begin
      mem_ff[wr_slot_ff][wr_ptr_ff[5:0]] <= rx_i.data;
    end
  end

  // Each committed packet records its length and moves the write slot.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      len_ff[0] <= 7'h00;
      len_ff[1] <= 7'h00;
      wr_slot_ff <= 1'b0;
    end else if (commit) begin
      len_ff[wr_slot_ff] <= wr_ptr_ff;
      wr_slot_ff <= ~wr_slot_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Unloading, flushing and the read side.
  // ----------------------------------------------------------------------

  // Firmware writing zero to the ready bit releases the packet.
  assign unload = wr_acc & (widx == UOES_IDX_CTRL_LOW) &
                  ~wbyte[UOES_LOW_READY] & ready_ff;
  // A pending flush discards the next unread packet.
  assign pop = (unload | flush_ff) & (pkt_cnt_ff != 2'h0);
  assign fifo_pop_byte = rd_acc & (widx == UOES_IDX_FIFO_DATA) &
                         (pkt_cnt_ff != 2'h0) &
                         (rd_ptr_ff < len_ff[rd_slot_ff]);

  // Packet count rises on commit and falls on each release.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pkt_cnt_ff <= 2'h0;
    end else begin
      pkt_cnt_ff <= pkt_cnt_ff + {1'b0, commit} - {1'b0, pop};
    end
  end

  // Read pointer is reset whenever a packet leaves the FIFO.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_ptr_ff <= 7'h00;
      rd_slot_ff <= 1'b0;
    end else if (pop) begin
      rd_ptr_ff <= 7'h00;
      rd_slot_ff <= ~rd_slot_ff;
    end else if (fifo_pop_byte) begin
      rd_ptr_ff <= rd_ptr_ff + 7'h01;
    end
  end

  // Flush bit is set by software and ends by itself one cycle later.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flush_ff <= 1'b0;
    end else if (flush_ff) begin
      flush_ff <= 1'b0;
    end else if (wr_acc & (widx == UOES_IDX_CTRL_LOW)) begin
      flush_ff <= wbyte[UOES_LOW_FLUSH];
    end
  end

  // ----------------------------------------------------------------------
  // Status flags.
  // ----------------------------------------------------------------------

  // Ready clears on release and re-arms while packets remain stored.
  always_comb begin
    nxt_ready = ready_ff;
    if (unload | flush_ff) begin
      nxt_ready = 1'b0;
    end else if (~ready_ff & (pkt_cnt_ff != 2'h0)) begin
      nxt_ready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= nxt_ready;
    end
  end

  // Lost flag: a new loss wins over a software clear.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lost_ff <= 1'b0;
    end else if (lost_ev) begin
      lost_ff <= 1'b1;
    end else if (wr_acc & (widx == UOES_IDX_CTRL_LOW) &
                 ~wbyte[UOES_LOW_LOST]) begin
      lost_ff <= 1'b0;
    end
  end

  // Data error clears when any stored packet is released or flushed; a new one wins.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      derr_ff <= 1'b0;
    end else if (derr_ev) begin
      derr_ff <= 1'b1;
    end else if (pop) begin
      derr_ff <= 1'b0;
    end
  end

  // Stall request and stall-sent flag.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stall_req_ff <= 1'b0;
      stall_sent_ff <= 1'b0;
    end else begin
      if (wr_acc & (widx == UOES_IDX_CTRL_LOW)) begin
        stall_req_ff <= wbyte[UOES_LOW_STALL_REQ];
      end
      if (stall_ev) begin
        stall_sent_ff <= 1'b1;
      end else if (wr_acc & (widx == UOES_IDX_CTRL_LOW) &
                   ~wbyte[UOES_LOW_STALL_SENT]) begin
        stall_sent_ff <= 1'b0;
      end
    end
  end

  // High control register: mode and buffering selection.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      iso_ff <= UOES_RST_CTRL[UOES_HIGH_ISO];
      dbl_ff <= UOES_RST_CTRL[UOES_HIGH_DBL];
    end else if (wr_acc & (widx == UOES_IDX_CTRL_HIGH)) begin
      iso_ff <= wbyte[UOES_HIGH_ISO];
      dbl_ff <= wbyte[UOES_HIGH_DBL];
    end
  end

  // Data toggle flips per accepted packet; software may reset it.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      toggle_ff <= 1'b0;
    end else if (wr_acc & (widx == UOES_IDX_CTRL_LOW) &
                 wbyte[UOES_LOW_CLR_TOGGLE]) begin
      toggle_ff <= 1'b0;
    end else if (commit) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts and handshake outputs.
  // ----------------------------------------------------------------------

  // Each ready rise, loss, stall and data error is an event.
  assign ev = {derr_ev, stall_ev, lost_ev, nxt_ready & ~ready_ff};

  // Sticky status: an event in the clear cycle keeps its bit.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_stat_ff <= UOES_RST_INT;
    end else if (wr_acc & (widx == UOES_IDX_INT_CLEAR)) begin
      int_stat_ff <= (int_stat_ff & ~wbyte[3:0]) | ev;
    end else begin
      int_stat_ff <= int_stat_ff | ev;
    end
  end

  // Interrupt enable register.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_en_ff <= UOES_RST_INT;
    end else if (wr_acc & (widx == UOES_IDX_INT_ENABLE)) begin
      int_en_ff <= wbyte[3:0];
    end
  end

  // Level interrupt while an enabled status bit is set.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(int_stat_ff & int_en_ff);
    end
  end

  // Handshake advice, registered for the USB engine.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_ff <= '0;
    end else begin
      hs_ff.stall <= stall_act;
      hs_ff.nak <= ~space & ~stall_act;
      hs_ff.toggle <= toggle_ff;
    end
  end

  assign hs_o = hs_ff;
  assign irq_o = irq_ff;

endmodule : uoes_top

// >>> tb/uoes_sva.sv
// Port checker for the OUT endpoint status block.
`timescale 1ns/10ps
module uoes_sva
  import uoes_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register bus.
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Packet stream, handshake advice and interrupt.
  input wire uoes_rx_t rx_i,
  input wire uoes_hs_t hs_o,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] quiet_ff;

  // Counts idle cycles since the last bus or link activity.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) quiet_ff <= 3'h0;
    else if (avs_read_i || avs_write_i || rx_i.valid || rx_i.eop)
      quiet_ff <= 3'h0;
    else if (quiet_ff != 3'h7) quiet_ff <= quiet_ff + 3'h1;
  end

  // The answer is a single low cycle, one cycle after the request.
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  bus_answer_a: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered in one cycle");
  idle_wait_a: assert property (!(avs_read_i || avs_write_i)
    |=> avs_waitrequest_o)
    else $error("waitrequest low without request");
  read_upper_a: assert property (!avs_waitrequest_o
    |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o &&
    (avs_address_i[7:2] < 6'h14 || avs_address_i[7:2] > 6'h19)
    |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property ($past(rst_i) |-> avs_waitrequest_o &&
    !irq_o && hs_o == 3'h0 && avs_readdata_o == 32'h0)
    else $error("outputs not at reset values");
  stall_nak_a: assert property (!(hs_o.stall && hs_o.nak))
    else $error("stall and nak together");
  flags_sticky_a: assert property (quiet_ff == 3'h7 |->
    $stable(hs_o) && $stable(irq_o))
    else $error("outputs moved without a cause");

  // Main scenarios reached.
  cover property ($rose(irq_o));
  cover property ($rose(hs_o.nak));
  cover property ($rose(hs_o.stall));
endmodule : uoes_sva

bind uoes_top uoes_sva i_uoes_sva (.sys_clk_i, .rst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_writedata_i,
  .avs_readdata_o, .avs_waitrequest_o, .rx_i, .hs_o, .irq_o);

// >>> tb/uoes_host_model.sv
// Host-side packet source feeding the endpoint receive stream.
`timescale 1ns/10ps
module uoes_host_model
  import uoes_pkg::*;
(
  // Clock.
  input wire logic sys_clk_i,
  // Packet stream.
  output uoes_rx_t rx_o
);
  logic [7:0] pend[$];
  logic go;
  logic crc;
  logic slow;
  logic gap_ff;

  initial begin
    rx_o = '0;
    go = 1'b0;
    crc = 1'b0;
    slow = 1'b0;
    gap_ff = 1'b0;
  end

  // Sends queued bytes, then the end marker; slow mode skips cycles.
  always @(posedge sys_clk_i) begin
    rx_o.valid <= 1'b0;
    rx_o.eop <= 1'b0;
    rx_o.crc_err <= 1'b0;
    rx_o.data <= ~rx_o.data; // Idle data keeps moving.
    gap_ff <= slow && !gap_ff;
    if (go && !gap_ff) begin
      if (pend.size() > 0) begin
        rx_o.valid <= 1'b1;
        rx_o.data <= pend.pop_front();
      end else begin
        rx_o.eop <= 1'b1;
        rx_o.crc_err <= crc;
        go <= 1'b0;
      end
    end
  end
endmodule : uoes_host_model

// >>> tb/uoes_top_test.sv
// Self-checking bench for the OUT endpoint status block.
`timescale 1ns/10ps
module uoes_top_test
  import uoes_pkg::*;
;
  localparam logic [7:0] A_LOW = UOES_IDX_CTRL_LOW << 2;
  localparam logic [7:0] A_HIGH = UOES_IDX_CTRL_HIGH << 2;
  localparam logic [7:0] A_STAT = UOES_IDX_INT_STATUS << 2;
  localparam logic [7:0] A_CLR = UOES_IDX_INT_CLEAR << 2;
  localparam logic [7:0] A_EN = UOES_IDX_INT_ENABLE << 2;
  localparam logic [7:0] A_DATA = UOES_IDX_FIFO_DATA << 2;
  logic clk, rst, rd, wr, wreq, irq;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata;
  uoes_rx_t rx;
  uoes_hs_t hs;
  int err_total = 0;
  int tests_run = 0;
  int seed = 32'h95337A76;
  logic [7:0] exp_q[$];
  logic [7:0] pkt[$];

  uoes_top i_uoes_top (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
    .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .rx_i(rx), .hs_o(hs), .irq_o(irq));
  uoes_host_model i_uoes_host_model (.sys_clk_i(clk), .rx_o(rx));

  // Clock and watchdog.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end

  task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask : cmp_data

  task automatic cmp_flag(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask : cmp_flag

  // Read answers are taken at the edge that sees waitrequest low.
  always @(posedge clk) begin
    if (rd && wreq === 1'b0 && exp_q.size() > 0)
      cmp_data(rdata, {24'h0, exp_q.pop_front()});
  end

  // The request stands until waitrequest is seen low; the watchdog ends a hang.
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [7:0] d, input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= {24'h0, d};
    be <= b;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 4'hF);
  endtask : put

  task automatic get(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 8'h00, 4'hF);
  endtask : get

  // Queues a random packet at the host and waits for its effects.
  task automatic send(input logic c);
    logic [7:0] b;
    int k;
    int n;
    pkt.delete();
    n = 1 + ($unsigned($random(seed)) % 8);
    for (k = 0; k < n; k++) begin
      b = 8'($random(seed));
      pkt.push_back(b);
      i_uoes_host_model.pend.push_back(b);
    end
    i_uoes_host_model.crc <= c;
    i_uoes_host_model.slow <= 1'($random(seed));
    @(posedge clk);
    i_uoes_host_model.go <= 1'b1;
    do @(posedge clk); while (i_uoes_host_model.go !== 1'b0);
    repeat (6) @(posedge clk);
  endtask : send

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // Main sequence.
  initial begin
    rst = 1'b1;
    {rd, wr, addr, wdata, be} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    get(A_LOW, 8'h00);
    get(A_HIGH, 8'h00);
    get(8'h7C, 8'h00);
    $display("test reset done");
    put(A_EN, 8'h0F);
    send(1'b0);
    get(A_LOW, 8'h03);
    get(A_STAT, 8'h01);
    cmp_flag(irq, 1'b1);
    cmp_flag(hs.nak, 1'b1);
    foreach (pkt[i]) get(A_DATA, pkt[i]);
    send(1'b0);
    get(A_LOW, 8'h07);
    get(A_STAT, 8'h03);
    put(A_LOW, 8'h00);
    get(A_LOW, 8'h00);
    put(A_CLR, 8'h0F);
    repeat (3) @(posedge clk);
    cmp_flag(irq, 1'b0);
    bus(A_HIGH, 1'b1, 8'h80, 4'h0);
    get(A_HIGH, 8'h00);
    $display("test single done");
    put(A_HIGH, 8'h80);
    send(1'b0);
    send(1'b0);
    get(A_LOW, 8'h03);
    put(A_CLR, 8'h0F);
    put(A_LOW, 8'h00);
    get(A_LOW, 8'h01);
    get(A_STAT, 8'h01);
    send(1'b0);
    // A flush acts one cycle late, then ready re-arms for what remains.
    put(A_LOW, 8'h11);
    repeat (2) @(posedge clk);
    get(A_LOW, 8'h01);
    put(A_LOW, 8'h11);
    repeat (2) @(posedge clk);
    get(A_LOW, 8'h00);
    $display("test double done");
    // Stall with a toggle reset; a packet then meets the stall.
    put(A_LOW, 8'hA0);
    repeat (2) @(posedge clk);
    cmp_flag(hs.stall, 1'b1);
    cmp_flag(hs.toggle, 1'b0);
    get(A_LOW, 8'h20);
    send(1'b0);
    get(A_LOW, 8'h60);
    get(A_STAT, 8'h05);
    put(A_LOW, 8'h00);
    repeat (2) @(posedge clk);
    cmp_flag(hs.stall, 1'b0);
    put(A_CLR, 8'h0F);
    // Isochronous mode keeps the stall request but ignores it.
    put(A_HIGH, 8'hC0);
    put(A_LOW, 8'h20);
    repeat (2) @(posedge clk);
    cmp_flag(hs.stall, 1'b0);
    send(1'b1);
    get(A_LOW, 8'h29);
    get(A_STAT, 8'h09);
    cmp_flag(hs.toggle, 1'b1);
    put(A_LOW, 8'h00);
    get(A_LOW, 8'h00);
    $display("test iso done");
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule : uoes_top_test
